// File: inc/msb_pkg.sv
package msb_pkg;
  // supply measurement in millivolts
  localparam int VOLT_W = 16;
  localparam logic [15:0] START_MV = 16'h128e; // 4750 mV
  localparam logic [15:0] DROP_MV = 16'h1194; // 4500 mV
  localparam logic [15:0] OVER_MV = 16'h34bc; // 13500 mV
  // clock and timing
  localparam int CLK_MHZ = 125;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // fault record bit positions
  localparam int FLT_RAIL = 0;
  localparam int FLT_OVER = 1;
  localparam int FLT_W = 2;
  localparam logic [1:0] FLT_NONE = 2'h0;

  typedef enum {
    MSB_OFF,
    MSB_RAMP,
    MSB_ON,
    MSB_FAULT
  } msb_state_t;

  typedef enum {
    MSB_BOOT_SPI,
    MSB_BOOT_MMC8,
    MSB_BOOT_SD4,
    MSB_BOOT_RSVD
  } msb_boot_t;
endpackage : msb_pkg

// File: design/msb_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser per bit
module msb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_next;

  // shift chain
  always_comb begin
    stage1_next = din;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign dout = stage2_reg;
endmodule : msb_sync

// File: design/msb_supervisor.sv
`timescale 1ns/1ps
// Operation
// - power up once input reaches start level
// - power off when input drops below dropout
// - restart automatically after undervoltage recovery
// - rail or overvoltage fault: off, latch flag
// - latched fault keeps off, red blinks
// - only power cycle clears latched faults
// - green on after power good, off on fail
// - red on in reset, blinks on overvoltage
// - two select pins choose boot source
// - first high second low is reserved
// - low/high: eight-bit MMC, flash unreachable
// - both low: four-bit SD, flash reachable
// - flash select zero never reaches carrier
// - no NAND boot path exists
// - four-bit mode: data0-3, flash, three selects
// - SPI and MMC pin sets mutually exclusive
// - reset input low holds processor in reset
// - reset input defaults active until driven high
// - module reset drives reset output active
module msb_supervisor
  import msb_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [VOLT_W-1:0] supplyMv,
  input wire logic railsGood,
  input wire logic resetIn_n,
  input wire logic resetInDriven,
  input wire logic boot_choice_first,
  input wire logic boot_choice_first_driven,
  input wire logic boot_choice_second,
  input wire logic boot_choice_second_driven,
  input wire logic [3:0] spiSelectIn_n,
  input wire logic [7:0] cardDataOut,
  input wire logic [7:0] cardDataOutEn_n,
  output logic moduleEnable,
  output logic cpuReset_n,
  output logic resetOut_n,
  output logic resetOutEn_n,
  output logic greenLed,
  output logic redLed,
  output logic [1:0] bootSource,
  output logic mmcWide,
  output logic bootFlashAvail,
  output logic boot_flash_select_n,
  output logic [2:0] carrierSelect_n,
  output logic [2:0] carrierSelectEn_n,
  output logic [3:0] card_data_line_four,
  output logic [3:0] cardHighEn_n,
  output logic [3:0] cardLowData,
  output logic [3:0] cardLowEn_n,
  output logic [1:0] faultFlags
);
  // refuse counts the timers cannot serve
  if (BLINK_CYCLES < 2 || SETTLE_CYCLES < 1) begin : g_bad_counts
    $error("msb_supervisor: counts too small");
  end

  // pin inputs synchronised; undriven selects and reset pulled per wiring
  logic [3:0] pinRaw;
  logic [3:0] pinSync;
  logic sel1Pin;
  logic sel2Pin;
  logic rstPin_n;
  logic pwrGood;
  logic railSync;
  assign sel1Pin = boot_choice_first_driven ? boot_choice_first : 1'b1;
  assign sel2Pin = boot_choice_second_driven ? boot_choice_second : 1'b1;
  assign rstPin_n = resetInDriven ? resetIn_n : 1'b0;
  assign pinRaw = {railsGood, rstPin_n, sel2Pin, sel1Pin};

  msb_sync #(
    .W(4),
    .INIT(4'h3) // selects idle high, reset and rails low
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din(pinRaw),
    .dout(pinSync)
  );
  assign railSync = pinSync[3];

  // supply samples also cross two stages
  logic [VOLT_W-1:0] volt1_reg;
  logic [VOLT_W-1:0] volt2_reg;
  logic [VOLT_W-1:0] volt1_next;
  logic [VOLT_W-1:0] volt2_next;
  always_comb begin
    volt1_next = supplyMv;
    volt2_next = volt1_reg;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      volt1_reg <= '0;
      volt2_reg <= '0;
    end else begin
      volt1_reg <= volt1_next;
      volt2_reg <= volt2_next;
    end
  end

  // thresholds judged only on a word seen twice, never one caught mid-change
  logic voltSteady;
  logic aboveStart;
  logic belowDrop;
  logic overVolt;
  assign voltSteady = volt1_reg == volt2_reg;
  assign aboveStart = voltSteady && volt2_reg >= START_MV;
  assign belowDrop = voltSteady && volt2_reg < DROP_MV;
  assign overVolt = voltSteady && volt2_reg > OVER_MV;

  // power sequencer; module reset is the only power-cycle equivalent
  msb_state_t state_reg;
  msb_state_t state_next;
  logic [31:0] settle_reg;
  logic [31:0] settle_next;
  logic [FLT_W-1:0] flt_reg;
  logic [FLT_W-1:0] flt_next;
  logic inRange;
  assign inRange = !overVolt && railSync;
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    flt_next = flt_reg;
    if (overVolt) begin
      flt_next[FLT_OVER] = 1'b1;
    end
    if (!railSync && state_reg == MSB_ON) begin
      flt_next[FLT_RAIL] = 1'b1;
    end
    unique case (state_reg)
      MSB_OFF: begin
        settle_next = '0;
        if (flt_next != FLT_NONE) begin
          state_next = MSB_FAULT;
        end else if (aboveStart) begin
          state_next = MSB_RAMP;
        end
      end
      MSB_RAMP: begin
        settle_next = settle_reg + 32'h1;
        if (flt_next != FLT_NONE) begin
          state_next = MSB_FAULT;
        end else if (belowDrop) begin
          state_next = MSB_OFF;
        end else if (settle_reg >= 32'(SETTLE_CYCLES - 1) && inRange) begin
          state_next = MSB_ON;
        end
      end
      MSB_ON: begin
        settle_next = '0;
        if (flt_next != FLT_NONE) begin
          state_next = MSB_FAULT;
        end else if (belowDrop) begin
          state_next = MSB_OFF;
        end
      end
      MSB_FAULT: begin
        settle_next = '0;
        state_next = MSB_FAULT;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= MSB_OFF;
      settle_reg <= '0;
      flt_reg <= FLT_NONE;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      flt_reg <= flt_next;
    end
  end

  // blink timer for red indicator
  logic [31:0] blink_reg;
  logic [31:0] blink_next;
  logic phase_reg;
  logic phase_next;
  always_comb begin
    blink_next = blink_reg + 32'h1;
    phase_next = phase_reg;
    if (blink_reg >= 32'(BLINK_CYCLES - 1)) begin
      blink_next = '0;
      phase_next = !phase_reg;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      blink_reg <= '0;
      phase_reg <= 1'b0;
    end else begin
      blink_reg <= blink_next;
      phase_reg <= phase_next;
    end
  end

  // boot decode; reserved code is passed out as its own source value with flash unavailable
  msb_boot_t boot;
  always_comb begin
    unique case ({pinSync[0], pinSync[1]})
      2'b11: boot = MSB_BOOT_SPI;
      2'b10: boot = MSB_BOOT_RSVD;
      2'b01: boot = MSB_BOOT_MMC8;
      default: boot = MSB_BOOT_SD4;
    endcase
  end

  // registered outputs
  logic powered;
  logic modRst;
  assign powered = state_reg == MSB_ON;
  assign pwrGood = powered && state_next == MSB_ON; // falls with the rails, not a cycle later
  assign modRst = !pwrGood || !pinSync[2];
  logic en_next;
  logic cpu_next;
  logic rst_next;
  logic green_next;
  logic red_next;
  logic [1:0] src_next;
  logic wide_next;
  logic avail_next;
  logic [2:0] csEn_next;
  logic [3:0] hiEn_next;
  always_comb begin
    en_next = pwrGood;
    cpu_next = !modRst;
    rst_next = !modRst;
    green_next = pwrGood;
    if (flt_reg[FLT_OVER] || state_reg == MSB_FAULT) begin
      red_next = phase_reg;
    end else begin
      red_next = modRst;
    end
    src_next = 2'(boot);
    wide_next = boot == MSB_BOOT_MMC8;
    avail_next = boot != MSB_BOOT_MMC8 && boot != MSB_BOOT_RSVD;
    csEn_next = wide_next ? 3'h7 : 3'h0;
    hiEn_next = wide_next ? cardDataOutEn_n[7:4] : 4'hf;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      moduleEnable <= 1'b0;
      cpuReset_n <= 1'b0;
      resetOut_n <= 1'b0;
      resetOutEn_n <= 1'b0;
      greenLed <= 1'b0;
      redLed <= 1'b1;
      bootSource <= 2'h0;
      mmcWide <= 1'b0;
      bootFlashAvail <= 1'b0;
      boot_flash_select_n <= 1'b1;
      carrierSelect_n <= 3'h7;
      carrierSelectEn_n <= 3'h7;
      card_data_line_four <= 4'h0;
      cardHighEn_n <= 4'hf;
      cardLowData <= 4'h0;
      cardLowEn_n <= 4'hf;
      faultFlags <= FLT_NONE;
    end else begin
      moduleEnable <= en_next;
      cpuReset_n <= cpu_next;
      resetOut_n <= rst_next;
      resetOutEn_n <= rst_next;
      greenLed <= green_next;
      redLed <= red_next;
      bootSource <= src_next;
      mmcWide <= wide_next;
      bootFlashAvail <= avail_next;
      boot_flash_select_n <= avail_next ? spiSelectIn_n[0] : 1'b1;
      carrierSelect_n <= spiSelectIn_n[3:1];
      carrierSelectEn_n <= csEn_next;
      card_data_line_four <= cardDataOut[7:4];
      cardHighEn_n <= hiEn_next;
      cardLowData <= cardDataOut[3:0];
      cardLowEn_n <= cardDataOutEn_n[3:0];
      faultFlags <= flt_reg;
    end
  end
endmodule : msb_supervisor

// File: testbench/msb_carrier.sv
`timescale 1ns/1ps
module msb_carrier (
  input wire logic [2:0] selMode,
  input wire logic relReset,
  input wire logic holdReset,
  output logic selA,
  output logic selB,
  output logic selADrv,
  output logic selBDrv,
  output logic rstN,
  output logic rstDrv
);
  // mode 4 floats both selects, pull-ups win; reserved code never applied
  always_comb begin
    selADrv = selMode != 3'h4;
    selBDrv = selADrv;
    selA = selMode[1] | selMode[2];
    selB = selMode[0] | selMode[2];
    rstDrv = relReset | holdReset;
    rstN = relReset; // undriven line sits at its active default
  end
endmodule : msb_carrier

// File: testbench/msb_checker_sva.sv
`timescale 1ns/1ps
module msb_checker_sva
  import msb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [VOLT_W-1:0] supplyMv,
  input wire logic moduleEnable,
  input wire logic cpuReset_n,
  input wire logic resetOut_n,
  input wire logic resetOutEn_n,
  input wire logic greenLed,
  input wire logic redLed,
  input wire logic [1:0] bootSource,
  input wire logic mmcWide,
  input wire logic bootFlashAvail,
  input wire logic boot_flash_select_n,
  input wire logic [2:0] carrierSelectEn_n,
  input wire logic [3:0] cardHighEn_n,
  input wire logic [1:0] faultFlags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // power, fault and indicator relations
  greenOn_a: assert property (greenLed |-> moduleEnable) else $error("green lit while off");
  dropOff_a:
    assert property ((supplyMv < DROP_MV) [*6] |-> !moduleEnable) else $error("low supply kept on");
  faultOff_a:
    assert property (faultFlags != FLT_NONE |=> !moduleEnable && !greenLed) else $error("on with fault");
  faultHold_a:
    assert property (($past(faultFlags) & ~faultFlags) == FLT_NONE) else $error("fault flag cleared");
  redMode_a:
    assert property (faultFlags == FLT_NONE && $stable(cpuReset_n) |-> redLed == !cpuReset_n)
    else $error("red wrong");
  rstOut_a:
    assert property (!cpuReset_n |-> !resetOut_n && !resetOutEn_n) else $error("reset out idle");
  // pin sharing relations
  narrowPins_a: assert property (!mmcWide |-> cardHighEn_n == 4'hf) else $error("high data driven");
  widePins_a:
    assert property (mmcWide |-> carrierSelectEn_n == 3'h7 && boot_flash_select_n && !bootFlashAvail)
    else $error("selects in wide mode");
  bootMap_a:
    assert property (bootSource[1] |-> bootFlashAvail == !bootSource[0] && !mmcWide) else $error("bad map");
  cover property (greenLed);
  cover property (faultFlags[1]);
  cover property (mmcWide);
endmodule : msb_checker_sva

bind msb_supervisor msb_checker_sva chk (.mclk(mclk), .reset(reset), .supplyMv(supplyMv),
  .moduleEnable(moduleEnable), .cpuReset_n(cpuReset_n), .resetOut_n(resetOut_n),
  .resetOutEn_n(resetOutEn_n), .greenLed(greenLed), .redLed(redLed), .bootSource(bootSource),
  .mmcWide(mmcWide), .bootFlashAvail(bootFlashAvail), .boot_flash_select_n(boot_flash_select_n),
  .carrierSelectEn_n(carrierSelectEn_n), .cardHighEn_n(cardHighEn_n), .faultFlags(faultFlags));

// File: testbench/module_supervisor_boot_select_tb.sv
`timescale 1ns/1ps
module module_supervisor_boot_select_tb;
  import msb_pkg::*;
  logic mclk = 1'h0, reset = 1'h1, railsGood = 1'h1, relReset = 1'h0, holdReset = 1'h0;
  logic [15:0] supplyMv = 16'h0;
  logic [2:0] selMode = 3'h3;
  logic [3:0] spiSelectIn_n = 4'h4;
  logic [7:0] cardDataOut = 8'ha5, cardDataOutEn_n = 8'h3c;
  logic selA, selB, selADrv, selBDrv, rstN, rstDrv, modEn, cpuRst_n, rstOut_n, rstOutEn_n;
  logic green, red, wide, avail, flashSel_n;
  logic [1:0] src, flags;
  logic [2:0] carSel_n, carSelEn_n;
  logic [3:0] hiData, hiEn_n, loData, loEn_n;
  logic [2:0] modes [4] = '{3'h3, 3'h1, 3'h0, 3'h4};
  logic [1:0] srcExp [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  int bad_count = 0, total_checks = 0, cycles = 0, n;
  // clock and run limit
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  msb_carrier board (.selMode(selMode), .relReset(relReset), .holdReset(holdReset), .selA(selA), .selB(selB),
    .selADrv(selADrv), .selBDrv(selBDrv), .rstN(rstN), .rstDrv(rstDrv));
  msb_supervisor #(.BLINK_CYCLES(4), .SETTLE_CYCLES(3)) uut (.mclk(mclk), .reset(reset),
    .supplyMv(supplyMv), .railsGood(railsGood), .resetIn_n(rstN), .resetInDriven(rstDrv),
    .boot_choice_first(selA), .boot_choice_first_driven(selADrv), .boot_choice_second(selB),
    .boot_choice_second_driven(selBDrv), .spiSelectIn_n(spiSelectIn_n), .cardDataOut(cardDataOut),
    .cardDataOutEn_n(cardDataOutEn_n), .moduleEnable(modEn), .cpuReset_n(cpuRst_n),
    .resetOut_n(rstOut_n), .resetOutEn_n(rstOutEn_n), .greenLed(green), .redLed(red),
    .bootSource(src), .mmcWide(wide), .bootFlashAvail(avail), .boot_flash_select_n(flashSel_n),
    .carrierSelect_n(carSel_n), .carrierSelectEn_n(carSelEn_n), .card_data_line_four(hiData),
    .cardHighEn_n(hiEn_n), .cardLowData(loData), .cardLowEn_n(loEn_n), .faultFlags(flags));
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic toggles(output int t);
    logic last;
    t = 0;
    last = red;
    repeat (16) begin
      cyc(1);
      if (red !== last) t++;
      last = red;
    end
  endtask : toggles
  task automatic pwr_cycle;
    reset = 1'h1;
    cyc(5);
    reset = 1'h0;
  endtask : pwr_cycle
  // scenarios
  task automatic t_power;
    supplyMv = START_MV - 16'h1;
    cyc(20);
    chk(16'(modEn), 16'h0);
    supplyMv = START_MV;
    cyc(12);
    chk(16'(modEn), 16'h1);
    chk(16'(green), 16'h1);
    chk(16'(cpuRst_n), 16'h0);
    chk(16'(rstOutEn_n), 16'h0);
    chk(16'(red), 16'h1);
    relReset = 1'h1;
    cyc(6);
    chk(16'(cpuRst_n), 16'h1);
    chk(16'(rstOutEn_n), 16'h1);
    chk(16'(red), 16'h0);
    chk(16'(rstOut_n), 16'h1);
    holdReset = 1'h1;
    relReset = 1'h0;
    cyc(6);
    chk(16'(cpuRst_n), 16'h0);
    chk(16'(rstOut_n), 16'h0);
    chk(16'(red), 16'h1);
    chk(16'(modEn), 16'h1);
    relReset = 1'h1;
    holdReset = 1'h0;
    cyc(6);
    chk(16'(cpuRst_n), 16'h1);
    $display("power done");
  endtask : t_power
  task automatic t_drop;
    supplyMv = DROP_MV;
    cyc(10);
    chk(16'(modEn), 16'h1);
    supplyMv = DROP_MV - 16'h1;
    cyc(6);
    chk(16'(modEn), 16'h0);
    chk(16'(green), 16'h0);
    supplyMv = START_MV - 16'h1;
    cyc(12);
    chk(16'(modEn), 16'h0);
    supplyMv = START_MV;
    cyc(12);
    chk(16'(modEn), 16'h1);
    $display("drop done");
  endtask : t_drop
  task automatic t_boot;
    for (int i = 0; i < 4; i++) begin
      selMode = modes[i];
      cyc(5);
      chk(16'(src), 16'(srcExp[i]));
      chk(16'(wide), 16'(modes[i] == 3'h1));
      chk(16'(avail), 16'(modes[i] != 3'h1));
      chk(16'(loData), 16'h5);
      chk(16'(loEn_n), 16'hc);
      if (modes[i] == 3'h1) begin
        chk(16'(carSelEn_n), 16'h7);
        chk(16'(hiData), 16'ha);
        chk(16'(flashSel_n), 16'h1);
        chk(16'(hiEn_n), 16'h3);
      end else begin
        chk(16'(carSelEn_n), 16'h0);
        chk(16'(flashSel_n), 16'h0);
        chk(16'(carSel_n), 16'h2);
        chk(16'(hiEn_n), 16'hf);
      end
    end
    $display("boot done");
  endtask : t_boot
  task automatic t_fault;
    railsGood = 1'h0;
    cyc(8);
    chk(16'(flags), 16'h1);
    railsGood = 1'h1;
    toggles(n);
    chk(16'(n > 1), 16'h1);
    chk(16'(modEn), 16'h0);
    supplyMv = 16'h34bd;
    pwr_cycle();
    cyc(20);
    chk(16'(flags), 16'h2);
    toggles(n);
    chk(16'(n > 1), 16'h1);
    supplyMv = START_MV;
    cyc(20);
    chk(16'(modEn), 16'h0);
    pwr_cycle();
    cyc(20);
    chk(16'(flags), 16'h0);
    chk(16'(modEn), 16'h1);
    $display("fault done");
  endtask : t_fault
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    cyc(5);
    reset = 1'h0;
    t_power();
    t_drop();
    t_boot();
    t_fault();
    close_out();
  end
endmodule : module_supervisor_boot_select_tb
